// ===== verilog/rtdr_defs.svh
// How it works
// - status word then eight channel readings
// - status word holds break and limit flags
// - flag readings above or below limits
// - break sets flag, holds last reading
// - error lamp on break of enabled channel
// - disable bit masks error lamp, status keeps last break flag
// - channels enabled unless their disable bit is set, reset has no effect
// - speed switch picks 50ms or 100ms period
// - scale switch picks Celsius or Fahrenheit
// - format switch picks raw or signed scaled
// - raw spans 0-7500 C, 0-13500 F
// - scaled equals temperature times ten
// - raw Celsius zero at -150 degrees
// - raw Fahrenheit zero at -238 degrees
// - twenty samples filtered per channel scan
// - conversion result has fifteen bit resolution
// - one type and range for all channels
// - configuration error blinks activity lamp slowly
`ifndef RTDR_DEFS_SVH
`define RTDR_DEFS_SVH
`define RTDR_CLK_HZ          200000000
`define RTDR_PERIOD_FAST_MS  50
`define RTDR_PERIOD_SLOW_MS  100
`define RTDR_SAMPLES         20
`define RTDR_RAW_C_OFFSET    1500
`define RTDR_RAW_F_OFFSET    2380
`define RTDR_RAW_C_MAX       7500
`define RTDR_RAW_F_MAX       13500
`define RTDR_STAT_BREAK_LSB  0
`define RTDR_STAT_LOW_LSB    8
`define RTDR_BLINK_MS        500
`endif

// ===== verilog/rtdr_pkg.sv
`default_nettype none
package rtdr_pkg;
    typedef enum logic [1:0]
    {
        RTDR_IDLE   = 2'b00,
        RTDR_SAMPLE = 2'b01,
        RTDR_STORE  = 2'b10
    } rtdr_state_t;
endpackage : rtdr_pkg
`default_nettype wire

// ===== verilog/rtdr_filter.sv
`include "rtdr_defs.svh"
`default_nettype none
// averages a burst of samples for one channel
module rtdr_filter #(
    parameter int SAMPLES = `RTDR_SAMPLES,
    parameter int WIDTH   = 15
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic             clear,
    input  wire logic             sample_valid,
    input  wire logic [WIDTH-1:0] sample_in,
    output logic      [WIDTH-1:0] average
);
    logic [WIDTH+5:0] sum_reg;
    logic [WIDTH+5:0] sum_next;
    assign sum_next = clear ? '0 : (sample_valid ? sum_reg + (WIDTH+6)'(sample_in) : sum_reg);
    assign average  = WIDTH'(sum_reg / (WIDTH+6)'(SAMPLES));
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            sum_reg <= '0;
        else
            sum_reg <= sum_next;
    end
endmodule : rtdr_filter
`default_nettype wire

// ===== verilog/rtdr_readout.sv
`include "rtdr_defs.svh"
`default_nettype none
// eight channel sensor readout: one scan per conversion period
module rtdr_readout #(
    parameter int CHANNELS  = 8,
    parameter int WIDTH     = 15,
    parameter int SAMPLES   = `RTDR_SAMPLES,
    parameter int CLK_HZ    = `RTDR_CLK_HZ,
    parameter int FAST_CYC  = CLK_HZ / 1000 * `RTDR_PERIOD_FAST_MS,
    parameter int SLOW_CYC  = CLK_HZ / 1000 * `RTDR_PERIOD_SLOW_MS,
    parameter int BLINK_CYC = CLK_HZ / 1000 * `RTDR_BLINK_MS
) (
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    input  wire logic                  speed_select_switch,
    input  wire logic                  scale_select_switch,
    input  wire logic                  format_select_switch,
    input  wire logic [CHANNELS-1:0]   conversion_disable,
    input  wire logic [CHANNELS-1:0]   low_limit_enable,
    input  wire logic [CHANNELS-1:0]   high_limit_enable,
    input  wire logic [CHANNELS*16-1:0] low_limit_value,
    input  wire logic [CHANNELS*16-1:0] high_limit_value,
    input  wire logic                  configuration_error,
    input  wire logic [WIDTH-1:0]      sample_data,
    input  wire logic [CHANNELS-1:0]   sensor_break,
    output logic                       sample_request,
    output logic [2:0]                 sample_channel,
    output logic [15:0]                status_word,
    output logic [CHANNELS*16-1:0]     channel_reading,
    output logic                       scan_done,
    output logic                       error_indicator,
    output logic                       activity_indicator
);
    logic [31:0]               timer_reg;
    logic [2:0]                chan_reg;
    logic [4:0]                count_reg;
    logic [31:0]               blink_reg;
    logic                      blink_reg_q;
    logic [CHANNELS-1:0]       break_reg;
    logic [CHANNELS-1:0]       low_reg;
    logic [CHANNELS-1:0]       high_reg;
    logic [CHANNELS*16-1:0]    reading_reg;
    rtdr_pkg::rtdr_state_t     state_reg;
    rtdr_pkg::rtdr_state_t     state_next;
    logic [31:0]               period_cyc;
    logic                      period_hit;
    logic                      last_sample;
    logic                      chan_live;
    logic                      do_store;
    logic [WIDTH-1:0]          avg;
    logic [16:0]               tenths_c;
    logic [16:0]               tenths;
    logic [16:0]               raw_val;
    logic signed [16:0]        scaled_val;
    logic [15:0]               out_val;
    logic signed [15:0]        lo_lim;
    logic signed [15:0]        hi_lim;
    logic                      is_low;
    logic                      is_high;

    // period by speed switch
    assign period_cyc  = speed_select_switch ? 32'(SLOW_CYC) : 32'(FAST_CYC);
    assign period_hit  = timer_reg >= period_cyc - 32'd1;
    assign last_sample = count_reg == 5'(SAMPLES - 1);
    assign chan_live   = !conversion_disable[chan_reg];
    assign do_store    = state_reg == rtdr_pkg::RTDR_STORE;

    always_comb
    begin
        case (state_reg)
            rtdr_pkg::RTDR_IDLE:
                state_next = period_hit ? rtdr_pkg::RTDR_SAMPLE : rtdr_pkg::RTDR_IDLE;
            rtdr_pkg::RTDR_SAMPLE:
                state_next = last_sample ? rtdr_pkg::RTDR_STORE : rtdr_pkg::RTDR_SAMPLE;
            rtdr_pkg::RTDR_STORE:
                state_next = (chan_reg == 3'(CHANNELS - 1)) ? rtdr_pkg::RTDR_IDLE
                                                            : rtdr_pkg::RTDR_SAMPLE;
            default:
                state_next = rtdr_pkg::RTDR_IDLE;
        endcase
    end

    // sensor sample: tenths of a degree C above -150 (0..7500), 15 bit
    rtdr_filter #(
        .SAMPLES (SAMPLES),
        .WIDTH   (WIDTH)
    ) u_filter (
        .clock        (clock),
        .reset_n      (reset_n),
        .clear        (do_store),
        .sample_valid (state_reg == rtdr_pkg::RTDR_SAMPLE),
        .sample_in    (sample_data),
        .average      (avg)
    );

    // Fahrenheit counts: C counts * 9 / 5, both zero at the range bottom
    assign tenths_c = 17'(avg);
    assign tenths   = scale_select_switch ? 17'((19'(tenths_c) * 19'd9) / 19'd5)
                                          : tenths_c;
    assign raw_val  = scale_select_switch
                      ? ((tenths > 17'(`RTDR_RAW_F_MAX)) ? 17'(`RTDR_RAW_F_MAX) : tenths)
                      : ((tenths > 17'(`RTDR_RAW_C_MAX)) ? 17'(`RTDR_RAW_C_MAX) : tenths);
    // scaled = raw minus offset: tenths of a degree
    assign scaled_val = $signed(raw_val) - (scale_select_switch
                        ? $signed(17'(`RTDR_RAW_F_OFFSET))
                        : $signed(17'(`RTDR_RAW_C_OFFSET)));
    assign out_val  = format_select_switch ? 16'(scaled_val) : 16'(raw_val);
    assign lo_lim   = $signed(low_limit_value[chan_reg*16 +: 16]);
    assign hi_lim   = $signed(high_limit_value[chan_reg*16 +: 16]);
    assign is_low   = low_limit_enable[chan_reg] &&
                      (format_select_switch ? ($signed(out_val) < lo_lim)
                                            : (out_val < 16'(lo_lim)));
    assign is_high  = high_limit_enable[chan_reg] &&
                      (format_select_switch ? ($signed(out_val) > hi_lim)
                                            : (out_val > 16'(hi_lim)));

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= rtdr_pkg::RTDR_IDLE;
            timer_reg <= '0;
            chan_reg  <= '0;
            count_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= (state_reg != rtdr_pkg::RTDR_IDLE || period_hit) ? 32'd0
                                                                         : timer_reg + 32'd1;
            count_reg <= (state_reg == rtdr_pkg::RTDR_SAMPLE && !last_sample)
                         ? count_reg + 5'd1 : 5'd0;
            if (do_store)
                chan_reg <= (chan_reg == 3'(CHANNELS - 1)) ? 3'd0 : chan_reg + 3'd1;
        end
    end

    // per channel result and flags
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            break_reg   <= '0;
            low_reg     <= '0;
            high_reg    <= '0;
            reading_reg <= '0;
        end
        else if (do_store && chan_live)
        begin
            break_reg[chan_reg] <= sensor_break[chan_reg];
            low_reg[chan_reg]   <= is_low;
            high_reg[chan_reg]  <= is_high;
            if (!sensor_break[chan_reg])
                reading_reg[chan_reg*16 +: 16] <= out_val;
        end
    end

    // published outputs: status and readings refreshed when the period timer expires, as the next scan starts
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            status_word     <= '0;
            channel_reading <= '0;
            scan_done       <= 1'b0;
            error_indicator <= 1'b0;
            sample_request  <= 1'b0;
            sample_channel  <= '0;
        end
        else
        begin
            scan_done      <= state_reg == rtdr_pkg::RTDR_IDLE && period_hit;
            sample_request <= state_next == rtdr_pkg::RTDR_SAMPLE;
            sample_channel <= (state_reg == rtdr_pkg::RTDR_STORE) ? chan_reg + 3'd1 : chan_reg;
            if (state_reg == rtdr_pkg::RTDR_IDLE && period_hit)
            begin
                status_word     <= {low_reg | high_reg, break_reg};
                channel_reading <= reading_reg;
            end
            error_indicator <= |(break_reg & ~conversion_disable);
        end
    end

    // slow blink on configuration error, steady on otherwise
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            blink_reg          <= '0;
            blink_reg_q        <= 1'b0;
            activity_indicator <= 1'b0;
        end
        else
        begin
            blink_reg <= (blink_reg >= 32'(BLINK_CYC - 1)) ? 32'd0 : blink_reg + 32'd1;
            if (blink_reg >= 32'(BLINK_CYC - 1))
                blink_reg_q <= !blink_reg_q;
            activity_indicator <= configuration_error ? blink_reg_q : 1'b1;
        end
    end
endmodule : rtdr_readout
`default_nettype wire

// ===== verification/rtdr_readout_chk.sv
`default_nettype none
module rtdr_readout_chk (
    input wire logic         clock,
    input wire logic         reset_n,
    input wire logic         configuration_error,
    input wire logic         sample_request,
    input wire logic [2:0]   sample_channel,
    input wire logic [15:0]  status_word,
    input wire logic [127:0] channel_reading,
    input wire logic         scan_done,
    input wire logic         error_indicator,
    input wire logic         activity_indicator
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    chk_outputs_hold: assert property (
        !scan_done |-> $stable(channel_reading) && $stable(status_word)) else $error("hold");
    chk_done_pulse: assert property (
        scan_done |=> !scan_done[*8]) else $error("done pulse");
    chk_burst_length: assert property (
        $rose(sample_request) |-> sample_request[*8] ##13 !sample_request) else $error("burst");
    chk_channel_steady: assert property (
        sample_request && $past(sample_request) |-> $stable(sample_channel)) else $error("chan");
    chk_error_cause: assert property (
        $rose(error_indicator) |-> ##[0:1000] status_word[7:0] != 8'h00) else $error("err");
    chk_lamp_fall: assert property (
        $fell(activity_indicator) |-> configuration_error || $past(configuration_error))
        else $error("lamp");
    chk_blink_half: assert property (
        configuration_error && $past(configuration_error) && $past(configuration_error, 2)
        && $changed(activity_indicator)
        |=> ($stable(activity_indicator) || !configuration_error)[*8]) else $error("blink");
    chk_scan_start: assert property (
        $rose(sample_request) && sample_channel == 3'd0 |-> scan_done) else $error("start");
    cov_scan: cover property (scan_done);
    cov_error: cover property ($rose(error_indicator));
    cov_blink: cover property ($fell(activity_indicator));
endmodule : rtdr_readout_chk
bind rtdr_readout rtdr_readout_chk u_chk (.clock(clock), .reset_n(reset_n),
    .configuration_error(configuration_error), .sample_request(sample_request),
    .sample_channel(sample_channel), .status_word(status_word),
    .channel_reading(channel_reading), .scan_done(scan_done),
    .error_indicator(error_indicator), .activity_indicator(activity_indicator));
`default_nettype wire

// ===== verification/rtdr_sensor_model.sv
`default_nettype none
module rtdr_sensor_model (
    input  wire logic         clock,
    input  wire logic         sample_request,
    input  wire logic [2:0]   sample_channel,
    input  wire logic [119:0] temps,
    output logic      [14:0]  sample_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       req_reg;
    logic [2:0] chan_reg;
    always_ff @(posedge clock)
    begin
        req_reg  <= sample_request;
        chan_reg <= sample_channel;
    end
    // line keeps the last channel's reading one cycle after request drops, then shows the inverse
    assign sample_data = sample_request ? temps[15*sample_channel +: 15]
                       : req_reg ? temps[15*chan_reg +: 15] : ~temps[15*chan_reg +: 15];
endmodule : rtdr_sensor_model
`default_nettype wire

// ===== verification/rtdr_readout_tb.sv
`default_nettype none
module rtdr_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic sc; logic fm; logic [15:0] base, e0, e7;} rtdr_row_t;
    rtdr_row_t rows [6] = '{'{1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0dac},
        '{1'b0, 1'b0, 16'h0fa0, 16'h0fa0, 16'h1d4c}, '{1'b1, 1'b0, 16'h0fa0, 16'h1c20, 16'h34bc},
        '{1'b0, 1'b1, 16'h0000, 16'hfa24, 16'h07d0}, '{1'b1, 1'b1, 16'h0000, 16'hf6b4, 16'h0f50},
        '{1'b1, 1'b1, 16'h0fa0, 16'h12d4, 16'h2b70}};
    logic         clock, reset_n, speed, scale, format, cfg_err, req, done, err_ind, act_ind;
    logic [7:0]   dis, lo_en, hi_en, brk;
    logic [127:0] lo_val, hi_val, rd;
    logic [119:0] temps;
    logic [14:0]  sdata;
    logic [2:0]   chan;
    logic [15:0]  status;
    int           errors, n_checks, cycles, t0, gap;
    rtdr_readout #(.FAST_CYC(100), .SLOW_CYC(200), .BLINK_CYC(16)) u_dut (.clock(clock),
        .reset_n(reset_n), .speed_select_switch(speed), .scale_select_switch(scale),
        .format_select_switch(format), .conversion_disable(dis), .low_limit_enable(lo_en),
        .high_limit_enable(hi_en), .low_limit_value(lo_val), .high_limit_value(hi_val),
        .configuration_error(cfg_err), .sample_data(sdata), .sensor_break(brk),
        .sample_request(req), .sample_channel(chan), .status_word(status),
        .channel_reading(rd), .scan_done(done), .error_indicator(err_ind),
        .activity_indicator(act_ind));
    rtdr_sensor_model u_sens (.clock(clock), .sample_request(req), .sample_channel(chan),
        .temps(temps), .sample_data(sdata));
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : cmp
    task automatic load(input int b);
        for (int c = 0; c < 8; c++) temps[15*c +: 15] = 15'(b + 500 * c);
    endtask : load
    task automatic scans(input int n);
        repeat (n)
        begin
            @(posedge clock);
            while (done !== 1'b1) @(posedge clock);
        end
        #1;
    endtask : scans
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end
    initial
    begin
        {speed, scale, format, cfg_err} = 4'h0;
        {dis, lo_en, hi_en, brk} = 32'h0000_0000;
        lo_val = '0;
        hi_val = '0;
        load(0);
        errors = 0;
        n_checks = 0;
        cycles = 0;
        reset_n = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        cmp("status", 16'h0000, status);
        reset_n = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        cmp("act", 16'h0001, 16'(act_ind));
        $display("test reset over");
        foreach (rows[i])
        begin
            {scale, format} = {rows[i].sc, rows[i].fm};
            load(rows[i].base);
            scans(3);
            cmp("ch0", rows[i].e0, rd[15:0]);
            cmp("ch7", rows[i].e7, rd[127:112]);
        end
        $display("test rows over");
        brk = 8'h80;
        load(0);
        scans(3);
        cmp("ch7", 16'h2b70, rd[127:112]);
        cmp("ch0", 16'hf6b4, rd[15:0]);
        cmp("brk", 16'h0080, status);
        cmp("err", 16'h0001, 16'(err_ind));
        dis = 8'h81;
        load(1000);
        scans(3);
        cmp("err", 16'h0000, 16'(err_ind));
        cmp("ch0", 16'hf6b4, rd[15:0]);
        cmp("ch1", 16'h0140, rd[31:16]);
        cmp("brk", 16'h0080, status);
        $display("test break over");
        {dis, brk} = 16'h0000;
        {scale, format} = 2'b00;
        {lo_en, hi_en} = 16'h0502;
        lo_val[15:0] = 16'h04b0;
        lo_val[47:32] = 16'h01f4;
        hi_val[31:16] = 16'h0578;
        scans(3);
        cmp("lim", 16'h0300, status);
        scans(1);
        t0 = cycles;
        scans(1);
        gap = cycles - t0;
        speed = 1'b1;
        scans(2);
        t0 = cycles;
        scans(1);
        cmp("gap", 16'h0064, 16'(cycles - t0 - gap));
        $display("test limits speed over");
        cfg_err = 1'b1;
        gap = 0;
        repeat (40)
        begin
            @(posedge clock);
            #1;
            gap += int'(act_ind === 1'b0);
        end
        cmp("blink", 16'h0001, 16'(gap > 8 && gap < 32));
        $display("test blink over");
        conclude();
    end
endmodule : rtdr_readout_tb
`default_nettype wire
